// File: hdl/ixd_exec.sv
// Purpose: execute unit for watchdog clear, call via W, complement,
//          clear, decrement and decrement-skip operations
// Assumes: decode path presents one operation with its operand value;
//          register file applies the bank to the 7-bit address
// Notes: W, status, latch, pc and stack state visible over APB
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - watchdog clear zeroes counter, sets both flags
// - watchdog clear also zeroes the prescaler
// - call via W pushes pc plus one
// - call target is latch bits and W
// - call takes two cycles, flags untouched
// - complement result routed by destination, sets zero
// - clear file writes zero, sets zero flag
// - decrement routed by destination, sets zero flag
// - clear W loads zero, sets zero flag
// - decrement-skip keeps flags, zero skips next
module ixd_exec
#(
    parameter int STACK_DEPTH = 16
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ixd_pkg::IXD_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic op_dest,
    input wire logic [6:0] op_file,
    input wire logic [7:0] op_fdata,
    output logic op_ready,
    output logic file_wr_en,
    output logic [6:0] file_wr_addr,
    output logic [7:0] file_wr_data,
    output logic [14:0] pc_out,
    output logic skip_next,
    output logic wdt_count_clr,
    output logic wdt_presc_clr
);

    localparam int CW = $clog2(STACK_DEPTH) + 1;

    // whole block state and its next value
    ixd_pkg::ixd_state_t st_q;
    ixd_pkg::ixd_state_t st_d;

    // alu result and zero test for the current operation
    logic [7:0] alu_res;
    logic alu_zero;

    // stack side
    logic stk_push;
    logic [14:0] stk_top;
    logic [CW-1:0] stk_cnt;

    // operation taken this cycle
    logic accept;
    // apb write commits at the access edge
    logic apb_wr;

    // true for every mapped register offset
    function automatic logic ixd_hit(input logic [ixd_pkg::IXD_ADDR_W-1:0] a);
        ixd_hit = (a == ixd_pkg::IXD_WREG_OFS) || (a == ixd_pkg::IXD_STATUS_OFS)
            || (a == ixd_pkg::IXD_LATCH_OFS) || (a == ixd_pkg::IXD_PC_OFS)
            || (a == ixd_pkg::IXD_STACK_OFS);
    endfunction

    // read word for an offset; unmapped reads as zero
    function automatic logic [31:0] ixd_rd(
        input logic [ixd_pkg::IXD_ADDR_W-1:0] a,
        input ixd_pkg::ixd_state_t s,
        input logic [14:0] top,
        input logic [CW-1:0] cnt
    );
        ixd_rd = '0;
        case (a)
            ixd_pkg::IXD_WREG_OFS: ixd_rd[7:0] = s.wreg;
            ixd_pkg::IXD_STATUS_OFS:
            begin
                ixd_rd[ixd_pkg::IXD_ZERO_BIT] = s.zero;
                ixd_rd[ixd_pkg::IXD_PD_BIT] = s.powerdown_flag;
                ixd_rd[ixd_pkg::IXD_TO_BIT] = s.timeout_flag;
            end
            ixd_pkg::IXD_LATCH_OFS: ixd_rd[6:0] = s.pc_upper_latch;
            ixd_pkg::IXD_PC_OFS: ixd_rd[14:0] = s.pc;
            ixd_pkg::IXD_STACK_OFS:
            begin
                ixd_rd[14:0] = top;
                ixd_rd[ixd_pkg::IXD_STK_CNT_POS +: CW] = cnt;
            end
            default: ixd_rd = '0;
        endcase
    endfunction

    // result of complement, decrement and clear operations
    ixd_alu u_alu
    (
        .op_code(op_code),
        .operand(op_fdata),
        .result(alu_res),
        .zero_out(alu_zero)
    );

    // return stack, pushed in the cycle the call is taken
    ixd_stack #(.DEPTH(STACK_DEPTH), .WIDTH(15)) u_stack
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .push(stk_push),
        .push_data(st_q.pc + ixd_pkg::IXD_PC_STEP),
        .top_q(stk_top),
        .count_q(stk_cnt)
    );

    // handshake and strobes
    assign accept = op_valid && st_q.op_ready;
    assign apb_wr = psel && penable && st_q.pready && pwrite;
    assign stk_push = accept && (op_code == ixd_pkg::IXD_CALL_VIA_WREG_OP);

    // next state: apb slave first, then the operation, so a
    // hardware flag update wins over a software write in one cycle
    always_comb
    begin
        st_d = st_q;
        // one-cycle pulses fall back every cycle
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.skip_next = 1'b0;
        st_d.wdt_clr = 1'b0;
        st_d.fwr_en = 1'b0;

        // setup phase: answer ready in the following access cycle
        if (psel && !penable)
        begin
            st_d.pready = 1'b1;
            st_d.pslverr = !ixd_hit(paddr);
            st_d.prdata = pwrite ? '0 : ixd_rd(paddr, st_q, stk_top, stk_cnt);
        end

        // software writes; pc and stack are read only
        if (apb_wr)
        begin
            case (paddr)
                ixd_pkg::IXD_WREG_OFS: st_d.wreg = pwdata[7:0];
                ixd_pkg::IXD_STATUS_OFS:
                begin
                    st_d.zero = pwdata[ixd_pkg::IXD_ZERO_BIT];
                    st_d.powerdown_flag = pwdata[ixd_pkg::IXD_PD_BIT];
                    st_d.timeout_flag = pwdata[ixd_pkg::IXD_TO_BIT];
                end
                ixd_pkg::IXD_LATCH_OFS: st_d.pc_upper_latch = pwdata[6:0];
                default: ;
            endcase
        end

        // second cycle of a two-cycle operation: idle slot
        if (!st_q.op_ready)
        begin
            st_d.op_ready = 1'b1;
            st_d.skip_pend = 1'b0;
            // the discarded fetch still used one program slot
            if (st_q.skip_pend)
            begin
                st_d.pc = st_q.pc + ixd_pkg::IXD_PC_STEP;
            end
        end

        // operation taken
        if (accept)
        begin
            st_d.pc = st_q.pc + ixd_pkg::IXD_PC_STEP;
            // file address is always the seven-bit operand
            st_d.fwr_addr = op_file;
            st_d.fwr_data = alu_res;
            case (op_code)
                ixd_pkg::IXD_WATCHDOG_CLEAR_OP:
                begin
                    // counter and prescaler clear share one strobe
                    st_d.wdt_clr = 1'b1;
                    st_d.timeout_flag = 1'b1;
                    st_d.powerdown_flag = 1'b1;
                end
                ixd_pkg::IXD_CALL_VIA_WREG_OP:
                begin
                    // push happens in parallel through stk_push
                    st_d.pc = {st_q.pc_upper_latch, st_q.wreg};
                    st_d.op_ready = 1'b0;
                end
                ixd_pkg::IXD_COMPLEMENT_FILE_OP,
                ixd_pkg::IXD_DECREMENT_FILE_OP:
                begin
                    // destination bit picks file or W
                    if (op_dest)
                    begin
                        st_d.fwr_en = 1'b1;
                    end
                    else
                    begin
                        st_d.wreg = alu_res;
                    end
                    st_d.zero = alu_zero;
                end
                ixd_pkg::IXD_CLEAR_FILE_OP:
                begin
                    // no destination choice, always the file
                    st_d.fwr_en = 1'b1;
                    st_d.zero = 1'b1;
                end
                ixd_pkg::IXD_CLEAR_WREG_OP:
                begin
                    st_d.wreg = alu_res;
                    st_d.zero = 1'b1;
                end
                ixd_pkg::IXD_DECREMENT_SKIP_ZERO_OP:
                begin
                    // routed like decrement, zero flag left alone
                    if (op_dest)
                    begin
                        st_d.fwr_en = 1'b1;
                    end
                    else
                    begin
                        st_d.wreg = alu_res;
                    end
                    // zero result: flush the fetch, idle one cycle
                    if (alu_zero)
                    begin
                        st_d.skip_next = 1'b1;
                        st_d.skip_pend = 1'b1;
                        st_d.op_ready = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q <= ixd_pkg::IXD_ST_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign op_ready = st_q.op_ready;
    assign file_wr_en = st_q.fwr_en;
    assign file_wr_addr = st_q.fwr_addr;
    assign file_wr_data = st_q.fwr_data;
    assign pc_out = st_q.pc;
    assign skip_next = st_q.skip_next;
    // counter and prescaler clear are the same event
    assign wdt_count_clr = st_q.wdt_clr;
    assign wdt_presc_clr = st_q.wdt_clr;

    // checks share one clock and the reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_wdt_flags_set: assert property (
        accept && op_code == ixd_pkg::IXD_WATCHDOG_CLEAR_OP
        |=> st_q.timeout_flag && st_q.powerdown_flag && wdt_count_clr)
        else $error("watchdog clear did not set flags");

    a_wdt_presc_clr: assert property (
        accept && op_code == ixd_pkg::IXD_WATCHDOG_CLEAR_OP
        |=> wdt_presc_clr
        ##1 (wdt_presc_clr == $past(accept && op_code == ixd_pkg::IXD_WATCHDOG_CLEAR_OP)))
        else $error("prescaler clear strobe wrong");

    a_call_push_top: assert property (
        stk_push |=> stk_top == $past(st_q.pc) + ixd_pkg::IXD_PC_STEP)
        else $error("return address not pushed");

    a_call_pc_load: assert property (
        stk_push |=> pc_out == {$past(st_q.pc_upper_latch), $past(st_q.wreg)})
        else $error("call target wrong");

    a_call_two_cycles: assert property (
        stk_push && !apb_wr
        |=> !op_ready && $stable(st_q.zero) && !file_wr_en ##1 op_ready)
        else $error("call not two cycles or flags moved");

    a_complement_file_op_result: assert property (
        accept && op_code == ixd_pkg::IXD_COMPLEMENT_FILE_OP
        |=> (($past(op_dest) && file_wr_en && file_wr_data == ~$past(op_fdata))
            || (!$past(op_dest) && !file_wr_en && st_q.wreg == ~$past(op_fdata)))
            && st_q.zero == ($past(op_fdata) == 8'hFF))
        else $error("complement result or zero wrong");

    a_clear_file_op_zero: assert property (
        accept && op_code == ixd_pkg::IXD_CLEAR_FILE_OP
        |=> file_wr_en && file_wr_data == 8'h00 && st_q.zero)
        else $error("clear file wrong");

    a_decrement_file_op_result: assert property (
        accept && op_code == ixd_pkg::IXD_DECREMENT_FILE_OP && !op_dest
        |=> st_q.wreg == $past(op_fdata) - 8'h01 && !file_wr_en
            && st_q.zero == ($past(op_fdata) == 8'h01))
        else $error("decrement to W wrong");

    a_clear_wreg_op_zero: assert property (
        accept && op_code == ixd_pkg::IXD_CLEAR_WREG_OP
        |=> st_q.wreg == 8'h00 && st_q.zero && !file_wr_en)
        else $error("clear W wrong");

    a_skip_nop: assert property (
        accept && op_code == ixd_pkg::IXD_DECREMENT_SKIP_ZERO_OP
        && op_fdata == 8'h01 && !apb_wr
        |=> skip_next && !op_ready && $stable(st_q.zero)
        ##1 op_ready && pc_out == $past(pc_out, 2) + 15'h0002)
        else $error("skip on zero wrong");

    a_file_addr: assert property (
        file_wr_en |-> file_wr_addr == $past(op_file) && $past(accept))
        else $error("file address not from operand");

endmodule
`default_nettype wire

// File: pkg/ixd_pkg.sv
// Purpose: shared constants and state type for the instruction execute block
// Assumes: 20 MHz mclk, APB register access with 32-bit data
// Notes: operation codes are local to this block, not the core's opcode map
package ixd_pkg;

    // apb address width
    localparam int IXD_ADDR_W = 8;

    // operation codes handed over by the decode path
    localparam logic [2:0] IXD_NO_OP = 3'h0;
    localparam logic [2:0] IXD_WATCHDOG_CLEAR_OP = 3'h1;
    localparam logic [2:0] IXD_CALL_VIA_WREG_OP = 3'h2;
    localparam logic [2:0] IXD_COMPLEMENT_FILE_OP = 3'h3;
    localparam logic [2:0] IXD_CLEAR_FILE_OP = 3'h4;
    localparam logic [2:0] IXD_DECREMENT_FILE_OP = 3'h5;
    localparam logic [2:0] IXD_CLEAR_WREG_OP = 3'h6;
    localparam logic [2:0] IXD_DECREMENT_SKIP_ZERO_OP = 3'h7;

    // register byte offsets
    localparam logic [7:0] IXD_WREG_OFS = 8'h00;
    localparam logic [7:0] IXD_STATUS_OFS = 8'h04;
    localparam logic [7:0] IXD_LATCH_OFS = 8'h08;
    localparam logic [7:0] IXD_PC_OFS = 8'h0C;
    localparam logic [7:0] IXD_STACK_OFS = 8'h10;

    // status register bit positions
    localparam int IXD_ZERO_BIT = 0;
    localparam int IXD_PD_BIT = 3;
    localparam int IXD_TO_BIT = 4;

    // stack register field position of the entry count
    localparam int IXD_STK_CNT_POS = 16;

    // reset values and arithmetic constants
    localparam logic [7:0] IXD_WREG_RST = 8'h00;
    localparam logic [6:0] IXD_LATCH_RST = 7'h00;
    localparam logic [14:0] IXD_PC_RST = 15'h0000;
    localparam logic IXD_FLAG_RST = 1'b1;
    localparam logic [7:0] IXD_CLEAR_VAL = 8'h00;
    localparam logic [7:0] IXD_DEC_STEP = 8'h01;
    localparam logic [14:0] IXD_PC_STEP = 15'h0001;

    // complete state of the execute block
    typedef struct packed {
        logic [7:0] wreg;
        logic zero;
        logic timeout_flag;
        logic powerdown_flag;
        logic [6:0] pc_upper_latch;
        logic [14:0] pc;
        logic op_ready;
        logic skip_pend;
        logic skip_next;
        logic wdt_clr;
        logic fwr_en;
        logic [6:0] fwr_addr;
        logic [7:0] fwr_data;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ixd_state_t;

    // state after reset: ready, timeout and power-down flags set, everything else cleared
    localparam ixd_state_t IXD_ST_RST = '{
        wreg: IXD_WREG_RST,
        timeout_flag: IXD_FLAG_RST,
        powerdown_flag: IXD_FLAG_RST,
        pc_upper_latch: IXD_LATCH_RST,
        pc: IXD_PC_RST,
        op_ready: 1'b1,
        default: '0
    };

endpackage

// File: hdl/ixd_alu.sv
// Purpose: result and zero test for the file register operations
// Assumes: purely combinational, same clock domain as its user
// Notes: unknown codes pass the operand through unchanged
`timescale 1ns/1ps
`default_nettype none
module ixd_alu
(
    input wire logic [2:0] op_code,
    input wire logic [7:0] operand,
    output logic [7:0] result,
    output logic zero_out
);

    // one result path shared by every file operation
    always_comb
    begin
        case (op_code)
            ixd_pkg::IXD_COMPLEMENT_FILE_OP: result = ~operand;
            ixd_pkg::IXD_DECREMENT_FILE_OP,
            ixd_pkg::IXD_DECREMENT_SKIP_ZERO_OP: result = operand - ixd_pkg::IXD_DEC_STEP;
            ixd_pkg::IXD_CLEAR_FILE_OP,
            ixd_pkg::IXD_CLEAR_WREG_OP: result = ixd_pkg::IXD_CLEAR_VAL;
            default: result = operand;
        endcase
        // zero test on the final result, used for flag and skip
        zero_out = (result == ixd_pkg::IXD_CLEAR_VAL);
    end

endmodule
`default_nettype wire

// File: hdl/ixd_stack.sv
// Purpose: hardware return stack written by the call path
// Assumes: push and data come from logic on mclk
// Notes: wraps when full, oldest entry lost; count saturates
`timescale 1ns/1ps
`default_nettype none
module ixd_stack
#(
    parameter int DEPTH = 16,
    parameter int WIDTH = 15
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_q,
    output logic [$clog2(DEPTH):0] count_q
);

    localparam int PW = $clog2(DEPTH);

    // entry storage, no reset needed
    logic [WIDTH-1:0] mem [DEPTH];
    // next free slot
    logic [PW-1:0] wptr_q;

    // entries are written only, return is outside this block
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wptr_q] <= push_data;
        end
    end

    // pointer, count and a registered copy of the top entry
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            wptr_q <= '0;
            count_q <= '0;
            top_q <= '0;
        end
        else if (push)
        begin
            wptr_q <= wptr_q + 1'b1;
            top_q <= push_data;
            if (count_q != (PW+1)'(DEPTH))
            begin
                count_q <= count_q + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// File: test/ixd_file_model.sv
// Purpose: file register model standing beside the execute block
// Assumes: one mclk domain; operand read is combinational
// Notes: a preload port lets the bench seed an operand before each operation
`timescale 1ns/1ps
`default_nettype none
module ixd_file_model
(
    input wire logic mclk,
    input wire logic pl_en,
    input wire logic [6:0] pl_addr,
    input wire logic [7:0] pl_data,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);
    // one bank of 128 locations behind a seven-bit address
    logic [7:0] mem [128];
    // read is immediate so the operand is current when the op is taken
    assign rd_data = mem[rd_addr];
    // design write lands after a preload of the same edge
    always @(posedge mclk)
    begin
        if (pl_en)
        begin
            mem[pl_addr] <= pl_data;
        end
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench for the execute block against an integer model
// Assumes: 20 MHz mclk, one APB word per register, ops spaced by a free cycle
// Notes: pc is assumed to move only on taken operations and the skipped slot
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, op_fdata, file_wr_data, pl_data;
    logic [31:0] pwdata, prdata, rd;
    logic op_valid, op_dest, op_ready, file_wr_en, skip_next, wdt_count_clr, wdt_presc_clr, pl_en;
    logic [2:0] op_code;
    logic [6:0] op_file, file_wr_addr, pl_addr;
    logic [14:0] pc_out;
    int mismatches, n_checks;
    int cyc = 0;
    // reference model state
    int w, z, to, pd, latch, pc, top, cnt;

    ixd_exec ixd_exec_i (.mclk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .op_valid, .op_code, .op_dest, .op_file, .op_fdata, .op_ready, .file_wr_en,
        .file_wr_addr, .file_wr_data, .pc_out, .skip_next, .wdt_count_clr, .wdt_presc_clr);
    ixd_file_model ixd_file_model_i (.mclk, .pl_en, .pl_addr, .pl_data, .wr_en(file_wr_en),
        .wr_addr(file_wr_addr), .wr_data(file_wr_data), .rd_addr(op_file), .rd_data(op_fdata));

    // free-running clock, 50 ns period
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // hang guard: the whole run needs well under 2000 cycles
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            mismatches++;
            results();
        end
    end

    // verdict and end of run
    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // four-state compare, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // request stands until an edge sees pready high; only the hang guard ends a wait
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        // answer taken at the completing edge, before the design updates
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // read back W, status and stack, compare with the model
    task automatic chk_state();
        apb(1'b0, ixd_pkg::IXD_WREG_OFS, 32'h0);
        chk(rd, 32'(w));
        apb(1'b0, ixd_pkg::IXD_STATUS_OFS, 32'h0);
        chk(rd, 32'(z + (pd << ixd_pkg::IXD_PD_BIT) + (to << ixd_pkg::IXD_TO_BIT)));
        apb(1'b0, ixd_pkg::IXD_STACK_OFS, 32'h0);
        chk(rd, 32'((cnt << ixd_pkg::IXD_STK_CNT_POS) + top));
    endtask

    // seed the operand, offer one operation, check its effects the cycle after
    task automatic op(input int code, input int dest, input int fa, input int fv);
        int r, wr, skip;
        @(posedge mclk);
        pl_en <= 1'b1;
        pl_addr <= 7'(fa);
        pl_data <= 8'(fv);
        @(posedge mclk);
        pl_en <= 1'b0;
        op_valid <= 1'b1;
        op_code <= 3'(code);
        op_dest <= 1'(dest);
        op_file <= 7'(fa);
        // held until an edge samples op_ready high, which is the taking edge
        @(posedge mclk);
        while (op_ready !== 1'b1)
            @(posedge mclk);
        op_valid <= 1'b0;
        r = 0;
        wr = 0;
        skip = 0;
        pc = (pc + 1) % 32768;
        case (code)
            1:
            begin
                to = 1;
                pd = 1;
            end
            2:
            begin
                top = pc;
                cnt = (cnt < 16) ? cnt + 1 : 16;
                pc = latch * 256 + w;
            end
            3: r = ~fv & 255;
            4: wr = 1;
            5, 7: r = (fv + 255) % 256;
            6: w = 0;
            // no-op only moves the program counter
            default: ;
        endcase
        if (code == 3 || code == 5 || code == 7)
        begin
            // destination bit routes the result
            if (dest == 1)
                wr = 1;
            else
                w = r;
        end
        if (code == 3 || code == 5)
            z = (r == 0);
        if (code == 4 || code == 6)
            z = 1;
        if (code == 7)
            skip = (r == 0);
        @(negedge mclk);
        chk(32'({file_wr_en, skip_next, wdt_count_clr, wdt_presc_clr, op_ready}),
            32'({1'(wr), 1'(skip), code == 1, code == 1, !(code == 2 || skip == 1)}));
        if (wr == 1)
            chk(32'({file_wr_addr, file_wr_data}), 32'(fa * 256 + r));
        chk(32'(pc_out), 32'(pc));
        // the discarded slot still advances the counter
        if (skip == 1)
            pc = (pc + 1) % 32768;
    endtask

    // random W and latch, one operation, then a W, status and stack read-back
    task automatic step(input int code);
        int v;
        v = $urandom % 256;
        apb(1'b1, ixd_pkg::IXD_WREG_OFS, 32'(v));
        w = v;
        v = $urandom % 128;
        apb(1'b1, ixd_pkg::IXD_LATCH_OFS, 32'(v));
        latch = v;
        // operand biased to the zero and skip boundaries
        case ($urandom % 4)
            0: v = 1;
            1: v = 0;
            default: v = $urandom % 256;
        endcase
        op(code, $urandom % 2, $urandom % 128, v);
        chk_state();
    endtask

    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, op_valid, op_dest, pl_en} = 6'h00;
        {paddr, pwdata, op_code, op_file, pl_addr, pl_data} = '0;
        {w, z, latch, pc, top, cnt} = '0;
        to = 1;
        pd = 1;
        void'($urandom(48));
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk_state();
        // unmapped place answers with an error and reads zero
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk(32'(err), 32'h1);
        // program counter is read-only
        apb(1'b1, ixd_pkg::IXD_PC_OFS, 32'h0000_1234);
        apb(1'b0, ixd_pkg::IXD_PC_OFS, 32'h0);
        chk(rd, 32'h0);
        // drop the flags so the watchdog clear has something to set
        apb(1'b1, ixd_pkg::IXD_STATUS_OFS, 32'h0);
        {to, pd} = '0;
        chk_state();
        for (int i = 0; i < 8; i++)
            step(i);
        repeat (60) step(1 + $urandom % 7);
        results();
    end
endmodule
`default_nettype wire
